// >>> logic/vpic_controller.sv
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Eight priority levels, a mask bit per source and a vector naming the chosen source.
// - Two request outputs go to the core: a fast one and a normal one.
// - Only the external fast request pin, or a software set of its pending bit in edge sense, can assert the fast request output.
// - Any enabled peripheral line or either enabled external request line asserts the normal request.
// - An eight level priority encoder picks among pending normal sources by software priority.
// - Each internal source is set by software to level or edge sensitivity.
// - Each external source senses rising edge, falling edge, high level or low level.
// - The registers sit in a 16 Kbyte window inside the top 1 Mbyte of the address map.
// - Frequently written registers have a set address, a clear address and a read address.
// - On set and clear addresses a written one acts on its bit and a zero does nothing.
module vpic_controller
   import vpic_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_INT-1:0] periph_irq_lines,
   input wire logic external_request_line_a,
   input wire logic external_request_line_b,
   input wire logic external_fast_request_pin,
   output logic core_normal_request_n,
   output logic core_fast_request_n
);

   // ******************************************
   // Decoding and priority pick helpers
   // ******************************************
   function automatic logic in_window(input logic [31:0] a);
      return (a[31:20] == WIN_TOP) && (a[19:14] == WIN_SLOT);
   endfunction

   function automatic logic wr_known(input logic [13:0] o);
      return o == OFS_EN_SET || o == OFS_EN_CLR || o == OFS_PEND_SET ||
             o == OFS_PEND_CLR || o == OFS_MODE_SET || o == OFS_MODE_CLR ||
             o == OFS_SENSE || o == OFS_PRIO0 ||
             o == OFS_PRIO0 + OFS_PRIO_STEP ||
             o == OFS_PRIO0 + 2 * OFS_PRIO_STEP;
   endfunction

   function automatic logic [1:0] resp_of(input logic [31:0] a,
                                          input logic known);
      if (!in_window(a)) begin
         return RESP_DECERR;
      end
      return known ? RESP_OKAY : RESP_SLVERR;
   endfunction

   function automatic logic [31:0] pick(input logic [NUM_NORM-1:0] act,
         input logic [NUM_NORM*PRIO_W-1:0] pr);
      logic found;
      logic [PRIO_W-1:0] best;
      logic [SRC_IDX_W-1:0] idx;
      found = 1'b0;
      best = PRIO_RESET;
      idx = '0;
      for (int s = 0; s < NUM_NORM; s++) begin
         if (act[s] && (!found || pr[s*PRIO_W +: PRIO_W] > best)) begin
            found = 1'b1;
            best = pr[s*PRIO_W +: PRIO_W];
            idx = SRC_IDX_W'(s);
         end
      end
      return {found, 20'h00000, best, 3'h0, idx};
   endfunction

   // ******************************************
   // State
   // ******************************************
   logic [NUM_SRC-1:0] en_reg;
   logic [NUM_SRC-1:0] pend_reg;
   logic [NUM_INT-1:0] mode_reg;
   logic [5:0] sense_reg;
   logic [PRIO_W-1:0] prio_reg [NUM_NORM];
   logic [NUM_INT-1:0] int_prev_reg;
   logic [NUM_EXT-1:0] s1_reg, s2_reg, s3_reg, ext_st_reg, ext_prev_reg;
   logic [31:0] vector_reg;
   logic normal_n_reg, fast_n_reg;
   logic aw_held_reg, w_held_reg, awready_reg, wready_reg;
   logic [31:0] aw_addr_reg, w_data_reg;
   logic [3:0] w_strb_reg;
   logic bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;

   logic [NUM_SRC-1:0] live, event_hit, is_level, eff_pend;
   logic [NUM_EXT-1:0] ext_pins;
   logic [NUM_NORM-1:0] active_norm;
   logic [NUM_NORM*PRIO_W-1:0] prio_flat;
   logic [31:0] prio_word [PRIO_WORDS];
   logic fast_active;
   logic [31:0] pick_word;

   // ******************************************
   // AXI write channel
   // ******************************************
   logic aw_fire, w_fire, do_write;
   logic aw_held_next, w_held_next, bvalid_next;
   logic [13:0] wofs;
   logic [31:0] wmask, wset;
   logic we_en_set, we_en_clr, we_pend_set, we_pend_clr;
   logic we_mode_set, we_mode_clr, we_sense;

   assign aw_fire = s_axi_awvalid && awready_reg;
   assign w_fire = s_axi_wvalid && wready_reg;
   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   assign aw_held_next = (aw_held_reg && !do_write) || aw_fire;
   assign w_held_next = (w_held_reg && !do_write) || w_fire;
   assign bvalid_next = do_write || (bvalid_reg && !s_axi_bready);
   assign wofs = aw_addr_reg[13:0];
   assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                   {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   assign wset = w_data_reg & wmask;
   // Only writes that land inside the window act
   assign we_en_set = do_write && in_window(aw_addr_reg) &&
                      wofs == OFS_EN_SET;
   assign we_en_clr = do_write && in_window(aw_addr_reg) &&
                      wofs == OFS_EN_CLR;
   assign we_pend_set = do_write && in_window(aw_addr_reg) &&
                        wofs == OFS_PEND_SET;
   assign we_pend_clr = do_write && in_window(aw_addr_reg) &&
                        wofs == OFS_PEND_CLR;
   assign we_mode_set = do_write && in_window(aw_addr_reg) &&
                        wofs == OFS_MODE_SET;
   assign we_mode_clr = do_write && in_window(aw_addr_reg) &&
                        wofs == OFS_MODE_CLR;
   assign we_sense = do_write && in_window(aw_addr_reg) &&
                     wofs == OFS_SENSE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_addr_reg <= 32'h00000000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= !aw_held_next && !bvalid_next;
         wready_reg <= !w_held_next && !bvalid_next;
         bvalid_reg <= bvalid_next;
         if (aw_fire) begin
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            bresp_reg <= resp_of(aw_addr_reg, wr_known(wofs));
         end
      end
   end

   // ******************************************
   // Control registers: enable and mode with set and clear aliases, sense written directly
   // ******************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_reg <= EN_RESET;
         mode_reg <= MODE_RESET;
         sense_reg <= SENSE_RESET;
      end else begin
         if (we_en_set) begin
            en_reg <= en_reg | wset[NUM_SRC-1:0];
         end else if (we_en_clr) begin
            en_reg <= en_reg & ~wset[NUM_SRC-1:0];
         end
         if (we_mode_set) begin
            mode_reg <= mode_reg | wset[NUM_INT-1:0];
         end else if (we_mode_clr) begin
            mode_reg <= mode_reg & ~wset[NUM_INT-1:0];
         end
         if (we_sense) begin
            sense_reg <= (sense_reg & ~wmask[5:0]) | wset[5:0];
         end
      end
   end

   // ******************************************
   // Internal sources: level or edge
   // ******************************************
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INT; gi++) begin : g_int
         assign is_level[gi] = !mode_reg[gi];
         assign live[gi] = periph_irq_lines[gi];
         assign event_hit[gi] = periph_irq_lines[gi] && !int_prev_reg[gi];
      end
   endgenerate

   // ******************************************
   // External pins: three-stage synchroniser
   // ******************************************
   assign ext_pins = {external_fast_request_pin, external_request_line_b,
                      external_request_line_a};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         ext_st_reg <= '0;
         ext_prev_reg <= '0;
         int_prev_reg <= '0;
      end else begin
         s1_reg <= ext_pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         ext_st_reg <= (s2_reg & s3_reg) | (ext_st_reg & (s2_reg | s3_reg));
         ext_prev_reg <= ext_st_reg;
         int_prev_reg <= periph_irq_lines;
      end
   end

   generate
      for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
         logic [1:0] sense;
         assign sense = sense_reg[2*gi +: 2];
         assign is_level[NUM_INT+gi] = sense[1];
         assign live[NUM_INT+gi] = (sense == SENSE_HIGH) ? ext_st_reg[gi] :
                                   !ext_st_reg[gi];
         assign event_hit[NUM_INT+gi] = (sense == SENSE_RISE) ?
               (ext_st_reg[gi] && !ext_prev_reg[gi]) :
               (!ext_st_reg[gi] && ext_prev_reg[gi]);
      end
   endgenerate

   // ******************************************
   // Pending state and routing
   // ******************************************
   // Edge pending is sticky; a new edge wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= ~is_level & (event_hit |
                     (we_pend_set ? wset[NUM_SRC-1:0] : '0) |
                     (pend_reg & ~(we_pend_clr ? wset[NUM_SRC-1:0] : '0)));
      end
   end

   assign eff_pend = (is_level & live) | (~is_level & pend_reg);
   assign active_norm = eff_pend[NUM_NORM-1:0] & en_reg[NUM_NORM-1:0];
   assign fast_active = eff_pend[SRC_FAST] && en_reg[SRC_FAST];

   // ******************************************
   // Priorities and vector
   // ******************************************
   generate
      for (gi = 0; gi < NUM_NORM; gi++) begin : g_prio
         localparam logic [13:0] OFS = OFS_PRIO0 + OFS_PRIO_STEP * 14'(gi / 8);
         localparam int LSB = 4 * (gi % 8);
         assign prio_flat[gi*PRIO_W +: PRIO_W] = prio_reg[gi];
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               prio_reg[gi] <= PRIO_RESET;
            end else if (do_write && in_window(aw_addr_reg) && wofs == OFS &&
                         w_strb_reg[LSB/8]) begin
               prio_reg[gi] <= w_data_reg[LSB +: PRIO_W];
            end
         end
      end
      for (gi = 0; gi < PRIO_WORDS * 8; gi++) begin : g_pword
         if (gi < NUM_NORM) begin : g_used
            assign prio_word[gi/8][4*(gi%8) +: 4] = {1'b0, prio_reg[gi]};
         end else begin : g_free
            assign prio_word[gi/8][4*(gi%8) +: 4] = 4'h0;
         end
      end
   endgenerate

   assign pick_word = pick(active_norm, prio_flat);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vector_reg <= 32'h00000000;
         normal_n_reg <= 1'b1;
         fast_n_reg <= 1'b1;
      end else begin
         vector_reg <= pick_word;
         normal_n_reg <= !(|active_norm);
         fast_n_reg <= !fast_active;
      end
   end

   // ******************************************
   // AXI read channel
   // ******************************************
   logic ar_fire, rvalid_next, rd_known;
   logic [13:0] rofs;
   logic [31:0] rd_word;

   assign ar_fire = s_axi_arvalid && arready_reg;
   assign rvalid_next = ar_fire || (rvalid_reg && !s_axi_rready);
   assign rofs = s_axi_araddr[13:0];

   always_comb begin
      rd_known = 1'b1;
      rd_word = 32'h00000000;
      if (rofs == OFS_EN_VAL) begin
         rd_word = 32'(en_reg);
      end else if (rofs == OFS_PEND_VAL) begin
         rd_word = 32'(eff_pend);
      end else if (rofs == OFS_MODE_VAL) begin
         rd_word = 32'(mode_reg);
      end else if (rofs == OFS_SENSE) begin
         rd_word = 32'(sense_reg);
      end else if (rofs == OFS_PRIO0) begin
         rd_word = prio_word[0];
      end else if (rofs == OFS_PRIO0 + OFS_PRIO_STEP) begin
         rd_word = prio_word[1];
      end else if (rofs == OFS_PRIO0 + 2 * OFS_PRIO_STEP) begin
         rd_word = prio_word[2];
      end else if (rofs == OFS_VECTOR) begin
         rd_word = vector_reg;
      end else if (rofs == OFS_STATUS) begin
         rd_word = 32'(ext_st_reg);
         rd_word[STAT_NORM_BIT] = !normal_n_reg;
         rd_word[STAT_FAST_BIT] = !fast_n_reg;
      end else begin
         rd_known = wr_known(rofs);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else begin
         arready_reg <= !rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_fire) begin
            rresp_reg <= resp_of(s_axi_araddr, rd_known);
            rdata_reg <= in_window(s_axi_araddr) ? rd_word : 32'h00000000;
         end
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign core_normal_request_n = normal_n_reg;
   assign core_fast_request_n = fast_n_reg;

   // ******************************************
   // Checks
   // ******************************************
   logic win_active;
   assign win_active = active_norm[vector_reg[SRC_IDX_W-1:0]];

   AST_FAST_ONLY_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
      !core_fast_request_n |-> $past(fast_active))
      else $error("fast request without fast pin source");
   AST_NORMAL_ASSERT: assert property (@(posedge aclk) disable iff (!aresetn)
      (|active_norm) |=> !core_normal_request_n)
      else $error("normal request missing while source pending");
   AST_NORMAL_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
      !(|active_norm) ##1 aresetn |-> core_normal_request_n)
      else $error("normal request held with nothing pending");
   AST_VECTOR_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
      (|active_norm) ##1 vector_reg[VEC_VALID_BIT] |->
      ((($past(active_norm) >> vector_reg[SRC_IDX_W-1:0]) & 18'h00001) != 0))
      else $error("vector names a source that was not pending");
   AST_VECTOR_VALID: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(|active_norm) |=> vector_reg[VEC_VALID_BIT])
      else $error("vector not valid after a source became pending");
   AST_EN_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      we_en_set |=> ((en_reg & $past(wset[NUM_SRC-1:0])) ==
                     $past(wset[NUM_SRC-1:0])) &&
                    ((en_reg & ~$past(wset[NUM_SRC-1:0])) ==
                     ($past(en_reg) & ~$past(wset[NUM_SRC-1:0]))))
      else $error("set alias did not act bit by bit");
   AST_EN_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
      we_en_clr |=> (en_reg == ($past(en_reg) & ~$past(wset[NUM_SRC-1:0]))))
      else $error("clear alias did not act bit by bit");
   AST_EDGE_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(event_hit & ~is_level)) |=> ((pend_reg & $past(event_hit & ~is_level))
                                      == $past(event_hit & ~is_level)))
      else $error("edge event was not latched");
   AST_EXT_LOW_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      (sense_reg[1:0] == SENSE_LOW && !ext_st_reg[EXT_A]) |->
      eff_pend[NUM_INT+EXT_A])
      else $error("low level external source not pending");
   AST_OUTSIDE_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && !in_window(aw_addr_reg)) |=>
      s_axi_bvalid && s_axi_bresp == RESP_DECERR && $stable(en_reg))
      else $error("write outside window not refused");

endmodule // vpic_controller

`default_nettype wire

// >>> logic/vpic_pkg.sv
package vpic_pkg;
   // ******************************************
   // Source layout
   // ******************************************
   localparam int NUM_INT = 16;
   localparam int NUM_EXT = 3;
   localparam int NUM_NORM = 18;
   localparam int NUM_SRC = 19;
   localparam int SRC_FAST = 18;
   localparam int EXT_A = 0;
   localparam int PRIO_W = 3;
   localparam int PRIO_WORDS = 3;
   localparam int SRC_IDX_W = 5;

   // ******************************************
   // Window in the top 1 Mbyte, 16 Kbyte wide
   // ******************************************
   localparam logic [11:0] WIN_TOP = 12'hfff;
   localparam logic [5:0] WIN_SLOT = 6'h3f;

   // ******************************************
   // Register offsets inside the window
   // ******************************************
   localparam logic [13:0] OFS_EN_SET = 14'h0000;
   localparam logic [13:0] OFS_EN_CLR = 14'h0004;
   localparam logic [13:0] OFS_EN_VAL = 14'h0008;
   localparam logic [13:0] OFS_PEND_SET = 14'h0010;
   localparam logic [13:0] OFS_PEND_CLR = 14'h0014;
   localparam logic [13:0] OFS_PEND_VAL = 14'h0018;
   localparam logic [13:0] OFS_MODE_SET = 14'h0020;
   localparam logic [13:0] OFS_MODE_CLR = 14'h0024;
   localparam logic [13:0] OFS_MODE_VAL = 14'h0028;
   localparam logic [13:0] OFS_SENSE = 14'h0030;
   localparam logic [13:0] OFS_PRIO0 = 14'h0040;
   localparam logic [13:0] OFS_PRIO_STEP = 14'h0004;
   localparam logic [13:0] OFS_VECTOR = 14'h0050;
   localparam logic [13:0] OFS_STATUS = 14'h0054;

   // ******************************************
   // Fields and reset values
   // ******************************************
   localparam logic [1:0] SENSE_RISE = 2'h0;
   localparam logic [1:0] SENSE_FALL = 2'h1;
   localparam logic [1:0] SENSE_HIGH = 2'h2;
   localparam logic [1:0] SENSE_LOW = 2'h3;
   localparam logic [5:0] SENSE_RESET = 6'h00;
   localparam logic [NUM_SRC-1:0] EN_RESET = 19'h00000;
   localparam logic [NUM_INT-1:0] MODE_RESET = 16'h0000;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
   localparam int VEC_VALID_BIT = 31;
   localparam int VEC_PRIO_LSB = 8;
   localparam int STAT_NORM_BIT = 8;
   localparam int STAT_FAST_BIT = 9;

   // ******************************************
   // AXI responses
   // ******************************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> testbench/vpic_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Core side of the request lines: counts cycles each request is held low
module vpic_core_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic core_normal_request_n,
   input wire logic core_fast_request_n,
   output var int normal_cycles,
   output var int fast_cycles
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         normal_cycles <= 0;
         fast_cycles <= 0;
      end else begin
         if (!core_normal_request_n) normal_cycles <= normal_cycles + 1;
         if (!core_fast_request_n) fast_cycles <= fast_cycles + 1;
      end
   end
endmodule // vpic_core_model

`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_top;
   import vpic_pkg::*;
   typedef struct {logic wr; logic [31:0] a; logic [31:0] d; logic [1:0] rs;} vpic_row_t;
   logic aclk = 0, aresetn = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [3:0] s_axi_wstrb = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, d0;
   logic [15:0] periph_irq_lines = 0;
   logic external_request_line_a = 0, external_request_line_b = 0;
   logic external_fast_request_pin = 0;
   logic core_normal_request_n, core_fast_request_n;
   int errors = 0, n_compared = 0, normal_cycles, fast_cycles;
   vpic_row_t rows [14];

   always #10 aclk = ~aclk;

   vpic_controller u_vpic_controller (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .periph_irq_lines, .external_request_line_a,
      .external_request_line_b, .external_fast_request_pin,
      .core_normal_request_n, .core_fast_request_n);
   vpic_core_model u_vpic_core_model (.aclk, .aresetn, .core_normal_request_n,
      .core_fast_request_n, .normal_cycles, .fast_cycles);

   // ****************************************
   // Bus tasks
   // ****************************************
   function automatic logic [31:0] ad(input logic [13:0] o);
      return {18'h3ffff, o};
   endfunction

   task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      rs = 2'h1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            rs = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rs = 2'h1;
      d = 32'hdead_beef;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rs = s_axi_rresp;
            d = s_axi_rdata;
            break;
         end
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] o, input logic [31:0] d);
      axw(ad(o), d, r);
      `CHK("bresp", RESP_OKAY, r)
   endtask

   task automatic rdc(input logic [13:0] o, input logic [31:0] m, input logic [31:0] e);
      axr(ad(o), d0, r);
      `CHK("rdata", e, d0 & m)
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic stop_test;
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      cyc(20000);
      errors++;
      stop_test;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rows = '{'{1, ad(OFS_EN_SET), 3, RESP_OKAY}, '{1, ad(OFS_EN_CLR), 1, RESP_OKAY},
         '{0, ad(OFS_EN_VAL), 2, RESP_OKAY}, '{1, ad(OFS_MODE_SET), 'hc, RESP_OKAY},
         '{1, ad(OFS_MODE_CLR), 4, RESP_OKAY}, '{0, ad(OFS_MODE_VAL), 8, RESP_OKAY},
         '{0, ad(OFS_EN_SET), 0, RESP_OKAY}, '{1, ad(14'h000c), 1, RESP_SLVERR},
         '{1, ad(OFS_VECTOR), 0, RESP_SLVERR}, '{0, 32'hfff00000, 0, RESP_DECERR},
         '{1, 32'hfffbc000, 1, RESP_DECERR}, '{1, ad(OFS_MODE_CLR), 8, RESP_OKAY},
         '{1, ad(OFS_EN_CLR), 2, RESP_OKAY}, '{0, ad(OFS_EN_VAL), 0, RESP_OKAY}};
      cyc(10);
      `CHK("normal_n", 1'b1, core_normal_request_n)
      `CHK("fast_n", 1'b1, core_fast_request_n)
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) axw(rows[i].a, rows[i].d, r);
         else begin
            axr(rows[i].a, d0, r);
            `CHK("row rdata", rows[i].d, d0)
         end
         `CHK("row resp", rows[i].rs, r)
      end
      wr(OFS_EN_SET, 32'h3);
      wr(OFS_PRIO0, 32'h50);
      periph_irq_lines <= 16'h0013;
      cyc(3);
      `CHK("normal_n", 1'b0, core_normal_request_n)
      `CHK("fast_n", 1'b1, core_fast_request_n)
      rdc(OFS_VECTOR, 32'h8000071f, 32'h80000501);
      periph_irq_lines <= 16'h0011;
      rdc(OFS_VECTOR, 32'h8000071f, 32'h80000000);
      periph_irq_lines <= 16'h0010;
      cyc(3);
      `CHK("masked", 1'b1, core_normal_request_n)
      wr(OFS_MODE_SET, 32'h4);
      wr(OFS_EN_SET, 32'h4);
      periph_irq_lines <= 16'h0004;
      cyc(1);
      periph_irq_lines <= 16'h0000;
      cyc(3);
      `CHK("edge held", 1'b0, core_normal_request_n)
      rdc(OFS_PEND_VAL, 32'h4, 32'h4);
      wr(OFS_PEND_CLR, 32'h4);
      cyc(2);
      `CHK("edge clr", 1'b1, core_normal_request_n)
      wr(OFS_EN_CLR, 32'h7);
      wr(OFS_EN_SET, 32'h10000);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_SENSE, s);
         external_request_line_a <= s[0];
         cyc(8);
         wr(OFS_PEND_CLR, 32'h10000);
         cyc(3);
         `CHK("ext idle", 1'b1, core_normal_request_n)
         external_request_line_a <= ~s[0];
         cyc(8);
         `CHK("ext act", 1'b0, core_normal_request_n)
         external_request_line_a <= s[0];
         cyc(8);
         `CHK("ext after", (s < 2) ? 1'b0 : 1'b1, core_normal_request_n)
         wr(OFS_PEND_CLR, 32'h10000);
      end
      wr(OFS_EN_CLR, 32'h10000);
      `CHK("fast count", 0, fast_cycles)
      wr(OFS_EN_SET, 32'h40000);
      wr(OFS_SENSE, 32'h20);
      external_fast_request_pin <= 1'b1;
      cyc(8);
      `CHK("fast_n", 1'b0, core_fast_request_n)
      `CHK("normal_n", 1'b1, core_normal_request_n)
      external_fast_request_pin <= 1'b0;
      cyc(8);
      `CHK("fast_n", 1'b1, core_fast_request_n)
      `CHK("fast count", 1'b1, fast_cycles > 0)
      `CHK("normal count", 1'b1, normal_cycles > 0)
      wr(OFS_EN_SET, 32'h20000);
      external_request_line_b <= 1'b1;
      cyc(8);
      `CHK("line b", 1'b0, core_normal_request_n)
      aresetn <= 1'b0;
      cyc(3);
      aresetn <= 1'b1;
      cyc(1);
      `CHK("normal_n", 1'b1, core_normal_request_n)
      rdc(OFS_EN_VAL, 32'hffffffff, 32'h0);
      stop_test;
   end
endmodule // tb_top

`default_nettype wire
